// File: hw/pwdb_map.svh
// Constants for the PWM generator with dead-band: offsets, fields, resets.
// How it works
// - Counter counts down, or up then down.
// - Direction low when down, high when up.
// - One-cycle pulses at zero and load value.
// - Down mode: load pulse right after zero.
// - Compare matches qualified by count direction.
// - Compare above load never matches.
// - Four events down mode, six up/down.
// - Matches ignored when zero or load coincide.
// - Coinciding matches: first uses A, second B.
// - Per event action: none, toggle, low, high.
// - Dead-band off passes both outputs unchanged.
// - Dead-band on: first output rise delayed.
// - Second output inverted, rise delayed after fall.
// - Selected events raise the interrupt.
// - Separately selected events pulse ADC trigger.
// - Interrupt and trigger use raw events.
// - Global reset can clear the counter.
// - Immediate mode: new values apply at zero.
// - Sync mode: apply at zero after update.
// - Fault enable forces output inactive; INTEN interrupts.
// - Stall: stop at zero or keep counting.
// - Per signal enable mask and final inversion.
// - Counter sync bit zeroes counter, self clears.
// - Disabled signal becomes zero, still inverted.
// - Fault forcing precedes the output inverter.
`ifndef PWDB_MAP_SVH
`define PWDB_MAP_SVH

// ==========================================================
// Register offsets
`define PWDB_OFF_CTL 12'h000
`define PWDB_OFF_SYNC 12'h004
`define PWDB_OFF_ENA 12'h008
`define PWDB_OFF_INV 12'h00C
`define PWDB_OFF_FLT 12'h010
`define PWDB_OFF_INTEN 12'h014
`define PWDB_OFF_STAT 12'h020
`define PWDB_OFF_GCTL 12'h040
`define PWDB_OFF_EVSEL 12'h044
`define PWDB_OFF_LOAD 12'h050
`define PWDB_OFF_COUNT 12'h054
`define PWDB_OFF_CMPA 12'h058
`define PWDB_OFF_CMPB 12'h05C
`define PWDB_OFF_GENA 12'h060
`define PWDB_OFF_GENB 12'h064
`define PWDB_OFF_DBCTL 12'h068
`define PWDB_OFF_DBRISE 12'h06C
`define PWDB_OFF_DBFALL 12'h070

// ==========================================================
// Field positions
`define PWDB_GCTL_EN 0
`define PWDB_GCTL_UD 1
`define PWDB_GCTL_DBGRUN 2
`define PWDB_GCTL_SYNCUPD 3
`define PWDB_EVSEL_TRG 8

// ==========================================================
// Reset values and answers
`define PWDB_RST_CNT 16'h0000
`define PWDB_RST_DLY 12'h000
`define PWDB_RST_MASK 2'h0
`define PWDB_RST_EVS 6'h00
`define PWDB_RST_GCTL 4'h0
`define PWDB_RST_WORD 32'h0000_0000
`define PWDB_DLY_MAX 12'hFFF
`define PWDB_RESP_OKAY 2'h0
`define PWDB_RESP_SLVERR 2'h2

`endif

// File: hw/pwdb_pkg.sv
// Types shared by the PWM generator with dead-band.
package pwdb_pkg;
  typedef logic [11:0] pwdb_addr_t;
  typedef logic [31:0] pwdb_word_t;
  typedef logic [3:0] pwdb_strb_t;
  typedef logic [1:0] pwdb_resp_t;
  typedef enum logic [1:0] {
    PWDB_ACT_NONE = 2'h0,
    PWDB_ACT_TOGGLE = 2'h1,
    PWDB_ACT_LOW = 2'h2,
    PWDB_ACT_HIGH = 2'h3
  } pwdb_act_t;
endpackage

// File: hw/pwdb_top.sv
// PWM generator with dead-band, output control and AXI4-Lite registers.
`timescale 1ns/1ns
`default_nettype none
`include "pwdb_map.svh"
module pwdb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire pwdb_pkg::pwdb_addr_t s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire pwdb_pkg::pwdb_word_t s_axi_wdata,
  input wire pwdb_pkg::pwdb_strb_t s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output pwdb_pkg::pwdb_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire pwdb_pkg::pwdb_addr_t s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pwdb_pkg::pwdb_word_t s_axi_rdata,
  output pwdb_pkg::pwdb_resp_t s_axi_rresp,
  input wire logic fault_in,
  input wire logic dbg_stall,
  output logic pin_out_zero,
  output logic pin_out_one,
  output logic irq,
  output logic adc_trig
);
  import pwdb_pkg::*;

  // ==========================================================
  // Declarations
  logic flt_m_q, flt_s_q, flt_p_q, stl_m_q, stl_s_q;
  logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  pwdb_resp_t bresp_q, rresp_q;
  pwdb_word_t rdata_q, wmask, wr_word;
  logic [32:0] rd_hw, wr_hw;
  logic wr_go, rd_go;
  logic upd_req_q, sync_q, flt_ie_q, db_en_q;
  logic [1:0] en_q, inv_q, flt_en_q, pin_q, pre, gated;
  logic [3:0] gctl_q;
  logic [5:0] isel_q, tsel_q, ev, ev_a, ev_b;
  logic [15:0] ld_sh_q, ca_sh_q, cb_sh_q, ld_act_q, ca_act_q, cb_act_q;
  logic [15:0] cnt_q, ld_nx;
  logic dir_q, run_c, upd_now, mode_ud, ma, mb, zl;
  logic [11:0] gena_q, genb_q, dbr_q, dbf_q, hi_cnt_q, lo_cnt_q;
  logic generator_out_first_q, generator_out_second_q;
  logic irq_q, trig_q, db_first, db_second;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flt_m_q <= 1'b0;
      flt_s_q <= 1'b0;
      flt_p_q <= 1'b0;
      stl_m_q <= 1'b0;
      stl_s_q <= 1'b0;
    end
    else
    begin
      flt_m_q <= fault_in;
      flt_s_q <= flt_m_q;
      flt_p_q <= flt_s_q;
      stl_m_q <= dbg_stall;
      stl_s_q <= stl_m_q;
    end
  end

  // ==========================================================
  // Register map
  function automatic logic [32:0] reg_word(pwdb_addr_t a);
    reg_word = {1'b1, `PWDB_RST_WORD};
    if (a == `PWDB_OFF_CTL)
      reg_word[0] = upd_req_q;
    else if (a == `PWDB_OFF_SYNC)
      reg_word[0] = sync_q;
    else if (a == `PWDB_OFF_ENA)
      reg_word[1:0] = en_q;
    else if (a == `PWDB_OFF_INV)
      reg_word[1:0] = inv_q;
    else if (a == `PWDB_OFF_FLT)
      reg_word[1:0] = flt_en_q;
    else if (a == `PWDB_OFF_INTEN)
      reg_word[0] = flt_ie_q;
    else if (a == `PWDB_OFF_STAT)
      reg_word[2:0] = {dir_q, stl_s_q, flt_s_q};
    else if (a == `PWDB_OFF_GCTL)
      reg_word[3:0] = gctl_q;
    else if (a == `PWDB_OFF_EVSEL)
      reg_word[13:0] = {tsel_q, 2'b00, isel_q};
    else if (a == `PWDB_OFF_LOAD)
      reg_word[15:0] = ld_sh_q;
    else if (a == `PWDB_OFF_COUNT)
      reg_word[15:0] = cnt_q;
    else if (a == `PWDB_OFF_CMPA)
      reg_word[15:0] = ca_sh_q;
    else if (a == `PWDB_OFF_CMPB)
      reg_word[15:0] = cb_sh_q;
    else if (a == `PWDB_OFF_GENA)
      reg_word[11:0] = gena_q;
    else if (a == `PWDB_OFF_GENB)
      reg_word[11:0] = genb_q;
    else if (a == `PWDB_OFF_DBCTL)
      reg_word[0] = db_en_q;
    else if (a == `PWDB_OFF_DBRISE)
      reg_word[11:0] = dbr_q;
    else if (a == `PWDB_OFF_DBFALL)
      reg_word[11:0] = dbf_q;
    else
      reg_word[32] = 1'b0;
  endfunction

  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_go = aw_rdy_q && s_axi_awvalid;
  assign rd_go = ar_rdy_q && s_axi_arvalid;

  always_comb
  begin
    rd_hw = reg_word(s_axi_araddr);
    wr_hw = reg_word(s_axi_awaddr);
    wr_word = (wr_hw[31:0] & ~wmask) | (s_axi_wdata & wmask);
  end

  // ==========================================================
  // AXI4-Lite write channel: address and data taken together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PWDB_RESP_OKAY;
    end
    else
    begin
      aw_rdy_q <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_q && !bvalid_q;
      w_rdy_q <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_q && !bvalid_q;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hw[32] ? `PWDB_RESP_OKAY : `PWDB_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= `PWDB_RST_WORD;
      rresp_q <= `PWDB_RESP_OKAY;
    end
    else
    begin
      ar_rdy_q <= s_axi_arvalid && !ar_rdy_q && !rvalid_q;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_hw[31:0];
        rresp_q <= rd_hw[32] ? `PWDB_RESP_OKAY : `PWDB_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q <= `PWDB_RST_MASK;
      inv_q <= `PWDB_RST_MASK;
      flt_en_q <= `PWDB_RST_MASK;
      flt_ie_q <= 1'b0;
      gctl_q <= `PWDB_RST_GCTL;
      isel_q <= `PWDB_RST_EVS;
      tsel_q <= `PWDB_RST_EVS;
      ld_sh_q <= `PWDB_RST_CNT;
      ca_sh_q <= `PWDB_RST_CNT;
      cb_sh_q <= `PWDB_RST_CNT;
      gena_q <= `PWDB_RST_DLY;
      genb_q <= `PWDB_RST_DLY;
      db_en_q <= 1'b0;
      dbr_q <= `PWDB_RST_DLY;
      dbf_q <= `PWDB_RST_DLY;
    end
    else if (wr_go)
    begin
      if (s_axi_awaddr == `PWDB_OFF_ENA)
        en_q <= wr_word[1:0];
      else if (s_axi_awaddr == `PWDB_OFF_INV)
        inv_q <= wr_word[1:0];
      else if (s_axi_awaddr == `PWDB_OFF_FLT)
        flt_en_q <= wr_word[1:0];
      else if (s_axi_awaddr == `PWDB_OFF_INTEN)
        flt_ie_q <= wr_word[0];
      else if (s_axi_awaddr == `PWDB_OFF_GCTL)
        gctl_q <= wr_word[3:0];
      else if (s_axi_awaddr == `PWDB_OFF_EVSEL)
      begin
        isel_q <= wr_word[5:0];
        tsel_q <= wr_word[13:8];
      end
      else if (s_axi_awaddr == `PWDB_OFF_LOAD)
        ld_sh_q <= wr_word[15:0];
      else if (s_axi_awaddr == `PWDB_OFF_CMPA)
        ca_sh_q <= wr_word[15:0];
      else if (s_axi_awaddr == `PWDB_OFF_CMPB)
        cb_sh_q <= wr_word[15:0];
      else if (s_axi_awaddr == `PWDB_OFF_GENA)
        gena_q <= wr_word[11:0];
      else if (s_axi_awaddr == `PWDB_OFF_GENB)
        genb_q <= wr_word[11:0];
      else if (s_axi_awaddr == `PWDB_OFF_DBCTL)
        db_en_q <= wr_word[0];
      else if (s_axi_awaddr == `PWDB_OFF_DBRISE)
        dbr_q <= wr_word[11:0];
      else if (s_axi_awaddr == `PWDB_OFF_DBFALL)
        dbf_q <= wr_word[11:0];
    end
  end

  // ==========================================================
  // Self-clearing controls; a fresh write wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upd_req_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      if (wr_go && s_axi_awaddr == `PWDB_OFF_CTL && wr_word[0])
        upd_req_q <= 1'b1;
      else if (upd_now && gctl_q[`PWDB_GCTL_SYNCUPD])
        upd_req_q <= 1'b0;
      if (wr_go && s_axi_awaddr == `PWDB_OFF_SYNC && wr_word[0])
        sync_q <= 1'b1;
      else
        sync_q <= 1'b0;
    end
  end

  // ==========================================================
  // Counter
  assign mode_ud = gctl_q[`PWDB_GCTL_UD];
  // Stall without the run option parks the count at zero
  assign run_c = gctl_q[`PWDB_GCTL_EN] && !(stl_s_q && !gctl_q[`PWDB_GCTL_DBGRUN] && cnt_q == 16'h0000);
  assign upd_now = cnt_q == 16'h0000 && (!gctl_q[`PWDB_GCTL_SYNCUPD] || upd_req_q);
  assign ld_nx = upd_now ? ld_sh_q : ld_act_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ld_act_q <= `PWDB_RST_CNT;
      ca_act_q <= `PWDB_RST_CNT;
      cb_act_q <= `PWDB_RST_CNT;
    end
    else if (upd_now)
    begin
      ld_act_q <= ld_sh_q;
      ca_act_q <= ca_sh_q;
      cb_act_q <= cb_sh_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= `PWDB_RST_CNT;
      dir_q <= 1'b0;
    end
    else if (sync_q)
    begin
      cnt_q <= `PWDB_RST_CNT;
      dir_q <= 1'b0;
    end
    else if (!mode_ud)
    begin
      dir_q <= 1'b0;
      if (run_c)
        cnt_q <= (cnt_q == 16'h0000) ? ld_nx : cnt_q - 16'h0001;
    end
    else if (run_c)
    begin
      if (dir_q)
      begin
        if (cnt_q >= ld_act_q)
        begin
          dir_q <= 1'b0;
          cnt_q <= (cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001;
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
      else if (cnt_q == 16'h0000)
      begin
        dir_q <= 1'b1;
        cnt_q <= (ld_nx == 16'h0000) ? cnt_q : 16'h0001;
      end
      else
        cnt_q <= cnt_q - 16'h0001;
    end
  end

  // ==========================================================
  // Events: 0 zero, 1 load, 2 A up, 3 A down, 4 B up, 5 B down
  assign ma = cnt_q == ca_act_q && ca_act_q <= ld_act_q;
  assign mb = cnt_q == cb_act_q && cb_act_q <= ld_act_q;
  assign zl = cnt_q == 16'h0000 || cnt_q == ld_act_q;
  assign ev[0] = run_c && cnt_q == 16'h0000;
  assign ev[1] = run_c && cnt_q == ld_act_q;
  assign ev[2] = run_c && ma && dir_q && !zl;
  assign ev[3] = run_c && ma && !dir_q && !zl;
  assign ev[4] = run_c && mb && dir_q && !zl;
  assign ev[5] = run_c && mb && !dir_q && !zl;
  assign ev_a = {ev[5:4] & {2{!(ev[2] || ev[3])}}, ev[3:0]};
  assign ev_b = {ev[5:4], ev[3:2] & {2{!(ev[4] || ev[5])}}, ev[1:0]};

  // Later events in the list override earlier ones in the same cycle
  function automatic logic gen_step(logic cur, logic [11:0] acts, logic [5:0] e);
    pwdb_act_t act;
    gen_step = cur;
    for (int i = 0; i < 6; i++)
    begin
      act = pwdb_act_t'(acts[2*i +: 2]);
      if (e[i])
      begin
        case (act)
          PWDB_ACT_TOGGLE: gen_step = !gen_step;
          PWDB_ACT_LOW: gen_step = 1'b0;
          PWDB_ACT_HIGH: gen_step = 1'b1;
          default: gen_step = gen_step;
        endcase
      end
    end
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      generator_out_first_q <= 1'b0;
      generator_out_second_q <= 1'b0;
    end
    else
    begin
      generator_out_first_q <= gen_step(generator_out_first_q, gena_q, ev_a);
      generator_out_second_q <= gen_step(generator_out_second_q, genb_q, ev_b);
    end
  end

  // ==========================================================
  // Dead-band: saturating high and low time counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hi_cnt_q <= `PWDB_RST_DLY;
      lo_cnt_q <= `PWDB_RST_DLY;
    end
    else
    begin
      if (!generator_out_first_q)
        hi_cnt_q <= `PWDB_RST_DLY;
      else if (hi_cnt_q != `PWDB_DLY_MAX)
        hi_cnt_q <= hi_cnt_q + 12'h001;
      if (generator_out_first_q)
        lo_cnt_q <= `PWDB_RST_DLY;
      else if (lo_cnt_q != `PWDB_DLY_MAX)
        lo_cnt_q <= lo_cnt_q + 12'h001;
    end
  end

  assign db_first = generator_out_first_q && hi_cnt_q >= dbr_q;
  assign db_second = !generator_out_first_q && lo_cnt_q >= dbf_q;
  assign pre = db_en_q ? {db_second, db_first} : {generator_out_second_q, generator_out_first_q};
  assign gated = pre & en_q & ~(flt_en_q & {2{flt_s_q}});

  // ==========================================================
  // Output stage, one flop per pin
  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pin_q[g] <= 1'b0;
      else
        pin_q[g] <= gated[g] ^ inv_q[g];
    end
  end

  // Stall adds nothing here; only events and fault onset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ev & isel_q) || (flt_ie_q && flt_s_q && !flt_p_q);
      trig_q <= |(ev & tsel_q);
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_out_zero = pin_q[0];
  assign pin_out_one = pin_q[1];
  assign irq = irq_q;
  assign adc_trig = trig_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_zero_then_load: assert property ((run_c && !mode_ud && ev[0]) ##1 (run_c && !mode_ud) |-> ev[1])
    else $error("load pulse missing after zero");
  a_dir_down: assert property (!mode_ud && $past(!mode_ud) |-> !dir_q)
    else $error("direction high in down mode");
  a_cmp_limit: assert property (ca_act_q > ld_act_q |-> !ev[2] && !ev[3])
    else $error("match above load value");
  a_match_mask: assert property (ev[0] || ev[1] |-> ev[5:2] == 4'h0)
    else $error("match with zero or load");
  a_sync_clear: assert property ($rose(sync_q) |=> cnt_q == 16'h0000 && !sync_q)
    else $error("counter sync failed");
  a_fault_pin: assert property (flt_s_q && flt_en_q[0] |=> pin_out_zero == $past(inv_q[0]))
    else $error("fault not forcing inactive");
  a_disabled_pin: assert property (!en_q[1] |=> pin_out_one == $past(inv_q[1]))
    else $error("disabled pin not constant");
  a_irq_event: assert property (|(ev & isel_q) |=> irq)
    else $error("interrupt missing");
  a_trig_event: assert property (|(ev & tsel_q) |=> adc_trig)
    else $error("trigger missing");
  a_imm_update: assert property (cnt_q == 16'h0000 && !gctl_q[3] |=> ld_act_q == $past(ld_sh_q))
    else $error("load not applied at zero");
  a_db_pass: assert property (!db_en_q |-> pre == {generator_out_second_q, generator_out_first_q})
    else $error("dead-band bypass broken");

  c_updown_turn: cover property (mode_ud && ev[1] ##1 !dir_q);
  c_db_gap: cover property (db_en_q && $fell(generator_out_first_q) ##1 !db_first && !db_second);
  c_fault_hit: cover property (flt_s_q && flt_en_q == 2'h3);
  c_stall_stop: cover property (stl_s_q && !run_c && gctl_q[0]);
endmodule
`default_nettype wire

// File: test/pwdb_bridge_model.sv
// Half-bridge driver model: gate overlap flag and a trip-driven fault line.
`timescale 1ns/1ns
`default_nettype none
module pwdb_bridge_model (
  input wire logic aclk,
  input wire logic hi_gate,
  input wire logic lo_gate,
  input wire logic trip_req,
  output logic fault_pin,
  output logic overlap
);
  // ==========================================================
  // Trip sense
  // Desaturation sense needs two cycles to flag a trip
  logic [1:0] trip_q;
  initial trip_q = 2'b00;
  always @(posedge aclk)
  begin
    trip_q <= {trip_q[0], trip_req};
  end
  assign fault_pin = trip_q[1];
  assign overlap = hi_gate & lo_gate;
endmodule
`default_nettype wire

// File: test/tb_pwdb_top.sv
// Self-checking bench for the PWM generator with dead-band.
`timescale 1ns/1ns
`default_nettype none
`include "pwdb_map.svh"
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_pwdb_top;
  import pwdb_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fault_in, dbg_stall, pin_out_zero, pin_out_one, irq, adc_trig, trip_req, overlap;
  pwdb_addr_t s_axi_awaddr, s_axi_araddr;
  pwdb_word_t s_axi_wdata, s_axi_rdata, rdat;
  pwdb_strb_t s_axi_wstrb;
  pwdb_resp_t s_axi_bresp, s_axi_rresp, last_resp;
  int failures, comparisons, h0, h1, ni, nt, nov;
  // Row: gctl, cmpa, cmpb, dbctl, invert, enable, pin0 highs, pin1 highs, irq per 90 cycles
  int rows[8][9] = '{'{1, 4, 7, 0, 0, 3, 54, 63, 9}, '{3, 4, 7, 0, 0, 3, 70, 35, 5},
    '{1, 4, 7, 0, 1, 3, 36, 63, 9}, '{1, 4, 7, 0, 1, 2, 90, 63, 9}, '{1, 20, 7, 0, 0, 3, 90, 63, 9},
    '{1, 0, 7, 0, 0, 3, 90, 63, 9}, '{1, 4, 4, 0, 0, 3, 54, 36, 9}, '{1, 4, 7, 1, 0, 3, 36, 9, 9}};

  pwdb_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .fault_in(fault_in),
    .dbg_stall(dbg_stall), .pin_out_zero(pin_out_zero), .pin_out_one(pin_out_one), .irq(irq), .adc_trig(adc_trig));
  pwdb_bridge_model bridge (.aclk(aclk), .hi_gate(pin_out_zero), .lo_gate(pin_out_one), .trip_req(trip_req),
    .fault_pin(fault_in), .overlap(overlap));

  // ==========================================================
  // Clock, closing and watchdog
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test();
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input pwdb_addr_t a, input int d);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= pwdb_word_t'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
      begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1)
      begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input pwdb_addr_t a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Whole periods in the window make the counts phase independent
  task automatic measure(input int n);
    h0 = 0;
    h1 = 0;
    ni = 0;
    nt = 0;
    nov = 0;
    repeat (n)
    begin
      @(posedge aclk);
      h0 += int'(pin_out_zero === 1'b1);
      h1 += int'(pin_out_one === 1'b1);
      ni += int'(irq === 1'b1);
      nt += int'(adc_trig === 1'b1);
      nov += int'(overlap === 1'b1);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {dbg_stall, trip_req, failures, comparisons} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pin_out_zero reset", 1'b0, pin_out_zero)
    `CHK("pin_out_one reset", 1'b0, pin_out_one)
    wr(`PWDB_OFF_LOAD, 9);
    wr(`PWDB_OFF_GENA, 32'h0000_0083);
    wr(`PWDB_OFF_GENB, 32'h0000_0C02);
    wr(`PWDB_OFF_EVSEL, 32'h0000_0201);
    wr(`PWDB_OFF_DBRISE, 2);
    wr(`PWDB_OFF_DBFALL, 3);
    for (int i = 0; i < 8; i++)
    begin
      wr(`PWDB_OFF_GCTL, rows[i][0]);
      wr(`PWDB_OFF_CMPA, rows[i][1]);
      wr(`PWDB_OFF_CMPB, rows[i][2]);
      wr(`PWDB_OFF_DBCTL, rows[i][3]);
      wr(`PWDB_OFF_INV, rows[i][4]);
      wr(`PWDB_OFF_ENA, rows[i][5]);
      repeat (40) @(posedge aclk);
      measure(90);
      `CHK("pin_out_zero highs", rows[i][6], h0)
      `CHK("pin_out_one highs", rows[i][7], h1)
      `CHK("irq pulses", rows[i][8], ni)
      `CHK("adc_trig pulses", rows[i][8], nt)
      if (rows[i][3] == 1)
        `CHK("overlap cycles", 0, nov)
    end
    // Held compare only moves after the update request
    wr(`PWDB_OFF_DBCTL, 0);
    wr(`PWDB_OFF_GCTL, 9);
    repeat (40) @(posedge aclk);
    wr(`PWDB_OFF_CMPA, 2);
    repeat (40) @(posedge aclk);
    measure(90);
    `CHK("pin_out_zero held", 54, h0)
    wr(`PWDB_OFF_CTL, 1);
    repeat (40) @(posedge aclk);
    measure(90);
    `CHK("pin_out_zero updated", 72, h0)
    wr(`PWDB_OFF_GCTL, 1);
    wr(`PWDB_OFF_CMPA, 20);
    wr(`PWDB_OFF_INV, 1);
    wr(`PWDB_OFF_FLT, 1);
    wr(`PWDB_OFF_INTEN, 1);
    wr(`PWDB_OFF_EVSEL, 0);
    repeat (40) @(posedge aclk);
    `CHK("pin_out_zero inverted", 1'b0, pin_out_zero)
    trip_req <= 1'b1;
    measure(10);
    `CHK("fault irq", 1, ni)
    `CHK("pin_out_zero fault", 1'b1, pin_out_zero)
    trip_req <= 1'b0;
    wr(`PWDB_OFF_FLT, 0);
    wr(`PWDB_OFF_EVSEL, 1);
    dbg_stall <= 1'b1;
    repeat (40) @(posedge aclk);
    measure(20);
    `CHK("stall irq", 0, ni)
    rd(`PWDB_OFF_COUNT);
    `CHK("stall count", 32'h0000_0000, rdat)
    wr(`PWDB_OFF_GCTL, 5);
    repeat (20) @(posedge aclk);
    measure(20);
    `CHK("stall run irq", 2, ni)
    dbg_stall <= 1'b0;
    wr(`PWDB_OFF_GCTL, 0);
    wr(`PWDB_OFF_SYNC, 1);
    rd(`PWDB_OFF_SYNC);
    `CHK("sync bit", 32'h0000_0000, rdat)
    rd(`PWDB_OFF_COUNT);
    `CHK("sync count", 32'h0000_0000, rdat)
    wr(12'h100, 32'h0000_FFFF);
    `CHK("unmapped bresp", `PWDB_RESP_SLVERR, last_resp)
    rd(12'h100);
    `CHK("unmapped rresp", `PWDB_RESP_SLVERR, last_resp)
    `CHK("unmapped rdata", 32'h0000_0000, rdat)
    // Toggle on zero halves the pin duty; then reset in mid-run
    wr(`PWDB_OFF_GENA, 1);
    wr(`PWDB_OFF_GCTL, 1);
    wr(`PWDB_OFF_ENA, 3);
    repeat (30) @(posedge aclk);
    measure(20);
    `CHK("pin_out_zero toggled", 10, h0)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pin_out_zero rerun", 1'b0, pin_out_zero)
    `CHK("pin_out_one rerun", 1'b0, pin_out_one)
    rd(`PWDB_OFF_ENA);
    `CHK("enable cleared", 32'h0000_0000, rdat)
    rd(`PWDB_OFF_COUNT);
    `CHK("count cleared", 32'h0000_0000, rdat)
    end_of_test();
  end
endmodule
`default_nettype wire
